// >>> design/ssc_top.sv
// Control logic of a three-section note step sequencer with Wishbone registers.
// Assumes pitch arrives as a semitone code and tick and keyboard inputs are synchronous to core_clk.
`timescale 1ns/1ps
`include "ssc_regs.svh"
module ssc_top #(
   parameter int EVENTS = `SSC_EVENTS,
   parameter int DUR_LIMIT = `SSC_DUR_LIMIT
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register bus
   input wire ssc_pkg::ssc_wb_req_t wbReq,
   output ssc_pkg::ssc_wb_rsp_t wbRsp,
   // Keyboard side
   input wire logic tickPulse,
   input wire logic keyboardPulseInput,
   input wire logic [5:0] pitchVoltageInput,
   // Synthesizer side
   output logic [6:0] pitchVoltageOutput,
   output logic notePulseOutput,
   output logic wraparoundPulseOutput,
   // Front panel indicators
   output ssc_pkg::ssc_panel_t panel
);
   import ssc_pkg::*;

   localparam logic [4:0] EV5 = EVENTS[4:0];

   typedef struct packed {
      ssc_mode_t mode;
      logic [1:0] sec;
      logic [1:0] baseSec;
      logic [4:0] idx;
      logic pend;
      logic [5:0] pendPitch;
      logic evStart;
      logic [8:0] remain;
      logic [2:0][4:0] lens;
      logic [7:0] ctrl;
      logic [2:0][6:0] shifts;
      logic [6:0] pitchOut;
      logic notePulse;
      logic wrapPulse;
      logic tickPrev;
      logic keyPrev;
      ssc_panel_t panel;
      ssc_wb_rsp_t rsp;
   } ssc_state_t;

   ssc_state_t q, d;

   logic [2:0] memWe;
   ssc_event_t memData;
   ssc_event_t rdEv [3];
   ssc_event_t curEv;
   logic cntClear;
   logic [8:0] cnt;
   logic cntHalf;
   logic busReq;
   logic [31:0] wrData;
   logic [2:0] loadCmd;
   logic [2:0] playCmd;
   logic finishCmd;
   logic tickRise;
   logic keyRise;
   logic [5:0] inPitch;
   ssc_pos_t nxt;

   if (EVENTS < 2 || EVENTS > 31) begin : gBadEvents
      $error("events per section out of range");
   end

   for (genvar g = 0; g < 3; g++) begin : gSec
      ssc_section_mem #(.DEPTH(EVENTS)) uMem (
         .core_clk(core_clk),
         .rst_n(rst_n),
         .wrEn(memWe[g]),
         .wrIdx(q.idx),
         .wrData(memData),
         .rdIdx(q.idx),
         .rdData(rdEv[g])
      );
   end

   ssc_tick_counter #(.LIMIT(DUR_LIMIT)) uCnt (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .tick(tickRise),
      .clear(cntClear),
      .count(cnt),
      .half(cntHalf)
   );

   function automatic logic chainOk(input logic [1:0] s, input logic [7:0] c);
      return (s == 2'd0 && c[`SSC_CTRL_CHAIN12]) ||
             (s == 2'd1 && c[`SSC_CTRL_CHAIN12] && c[`SSC_CTRL_CHAIN23]);
   endfunction

   // Position after the current event: next in section, next chained section, or wrap to base
   function automatic ssc_pos_t nextPos(input logic [1:0] s, input logic [4:0] i, input logic [1:0] b,
                                        input logic [2:0][4:0] l, input logic [7:0] c);
      ssc_pos_t p;
      logic [1:0] n;
      n = (s == 2'd2) ? 2'd2 : s + 2'd1;
      p.sec = b;
      p.idx = 5'd0;
      p.wrap = 1'b1;
      if (i + 5'd1 < l[s]) begin
         p.sec = s;
         p.idx = i + 5'd1;
         p.wrap = 1'b0;
      end else if (l[s] == EV5 && chainOk(s, c) && l[n] != 5'd0) begin
         p.sec = n;
         p.wrap = 1'b0;
      end
      return p;
   endfunction

   function automatic logic [1:0] firstSet(input logic [2:0] v);
      return v[0] ? 2'd0 : (v[1] ? 2'd1 : 2'd2);
   endfunction

   // Adds the selected offset and clamps to the output range
   function automatic logic [6:0] shifted(input logic [5:0] p, input logic [7:0] c, input logic [2:0][6:0] o);
      logic [1:0] sel;
      logic [8:0] sum;
      sel = c[`SSC_CTRL_SHSEL_LO +: 2];
      sum = {3'b000, p};
      if (sel != 2'd0) begin
         sum = sum + {{2{o[sel - 2'd1][6]}}, o[sel - 2'd1]};
      end
      if (sum[8]) begin
         return 7'h00;
      end else if (sum[7]) begin
         return 7'h7F;
      end
      return sum[6:0];
   endfunction

   always_comb begin
      d = q;
      d.notePulse = 1'b0;
      d.wrapPulse = 1'b0;
      d.rsp.ack = 1'b0;
      d.tickPrev = tickPulse;
      d.keyPrev = keyboardPulseInput;
      tickRise = tickPulse && !q.tickPrev;
      keyRise = keyboardPulseInput && !q.keyPrev;
      memWe = 3'b000;
      memData = '0;
      cntClear = 1'b0;
      loadCmd = 3'b000;
      playCmd = 3'b000;
      finishCmd = 1'b0;
      curEv = rdEv[q.sec];
      nxt = nextPos(q.sec, q.idx, q.baseSec, q.lens, q.ctrl);
      inPitch = (pitchVoltageInput > 6'(`SSC_PITCH_LEVELS - 1)) ? 6'(`SSC_PITCH_LEVELS - 1)
                                                                 : pitchVoltageInput;
      busReq = wbReq.cyc && wbReq.stb && !q.rsp.ack;
      for (int i = 0; i < 4; i++) begin
         wrData[8*i +: 8] = wbReq.sel[i] ? wbReq.dat[8*i +: 8] : 8'h00;
      end

      // Register bus slave, one cycle to ack, unmapped reads zero
      if (busReq) begin
         d.rsp.ack = 1'b1;
         d.rsp.dat = 32'h0000_0000;
         if (wbReq.adr == `SSC_OFS_CTRL) begin
            if (wbReq.we && wbReq.sel[0]) begin
               d.ctrl = wrData[7:0] & `SSC_CTRL_MASK;
            end
            d.rsp.dat = {24'h00_0000, q.ctrl};
         end else if (wbReq.adr == `SSC_OFS_CMD) begin
            if (wbReq.we) begin
               loadCmd = wrData[`SSC_CMD_LOAD_LO +: 3];
               playCmd = wrData[`SSC_CMD_PLAY_LO +: 3];
               finishCmd = wrData[`SSC_CMD_FINISH];
            end
         end else if (wbReq.adr == `SSC_OFS_SHIFT1 || wbReq.adr == `SSC_OFS_SHIFT2 ||
                      wbReq.adr == `SSC_OFS_SHIFT3) begin
            if (wbReq.we && wbReq.sel[0]) begin
               d.shifts[2'((wbReq.adr - `SSC_OFS_SHIFT1) >> 2)] = wrData[6:0];
            end
            d.rsp.dat = {25'h000_0000, q.shifts[2'((wbReq.adr - `SSC_OFS_SHIFT1) >> 2)]};
         end else if (wbReq.adr == `SSC_OFS_STATUS) begin
            d.rsp.dat[`SSC_STAT_MODE_LO +: 2] = q.mode;
            d.rsp.dat[`SSC_STAT_SEC_LO +: 2] = q.panel.sec;
            d.rsp.dat[`SSC_STAT_CNT_LO +: 5] = q.panel.cnt;
            d.rsp.dat[`SSC_STAT_FULL] = q.panel.full;
            d.rsp.dat[`SSC_STAT_LONG] = q.panel.longDur;
         end else if (wbReq.adr == `SSC_OFS_LEN) begin
            d.rsp.dat = {8'h00, 3'b000, q.lens[2], 3'b000, q.lens[1], 3'b000, q.lens[0]};
         end
      end

      if (|loadCmd && !finishCmd) begin
         d.mode = SSC_LOAD;
         d.sec = firstSet(loadCmd);
         d.baseSec = firstSet(loadCmd);
         d.idx = 5'd0;
         d.pend = 1'b0;
         d.evStart = 1'b0;
         d.lens[firstSet(loadCmd)] = 5'd0;
         cntClear = 1'b1;
      end else if (|playCmd && !finishCmd) begin
         if (q.ctrl[`SSC_CTRL_STEP] && q.mode == SSC_PLAY && q.baseSec == firstSet(playCmd) && !q.evStart) begin
            d.sec = nxt.sec;
            d.idx = nxt.idx;
            d.wrapPulse = nxt.wrap;
            d.evStart = 1'b1;
         end else if (q.lens[firstSet(playCmd)] != 5'd0) begin
            d.mode = SSC_PLAY;
            d.sec = firstSet(playCmd);
            d.baseSec = firstSet(playCmd);
            d.idx = 5'd0;
            d.evStart = 1'b1;
         end
      end else begin
         case (q.mode)
            SSC_LOAD: begin
               if (finishCmd) begin
                  if (q.pend) begin
                     memWe[q.sec] = 1'b1;
                     memData = '{pitch: q.pendPitch, dur: cnt};
                     d.lens[q.sec] = q.idx + 5'd1;
                  end
                  d.pend = 1'b0;
                  if (q.pend || q.lens[q.baseSec] != 5'd0) begin
                     d.mode = SSC_PLAY;
                     d.sec = q.baseSec;
                     d.idx = 5'd0;
                     d.evStart = 1'b1;
                  end else begin
                     d.mode = SSC_IDLE;
                  end
               end else if (keyRise) begin
                  if (q.pend) begin
                     memWe[q.sec] = 1'b1;
                     memData = '{pitch: q.pendPitch, dur: cnt};
                     d.lens[q.sec] = q.idx + 5'd1;
                     cntClear = 1'b1;
                     d.pendPitch = inPitch;
                     if (q.idx + 5'd1 < EV5) begin
                        d.idx = q.idx + 5'd1;
                     end else if (chainOk(q.sec, q.ctrl)) begin
                        d.sec = q.sec + 2'd1;
                        d.idx = 5'd0;
                        d.lens[q.sec + 2'd1] = 5'd0;
                     end else begin
                        d.pend = 1'b0;
                        d.idx = EV5;
                     end
                  end else if (q.idx != EV5) begin
                     d.pend = 1'b1;
                     d.pendPitch = inPitch;
                     cntClear = 1'b1;
                  end
               end
            end
            SSC_PLAY: begin
               if (finishCmd) begin
                  d.mode = SSC_IDLE;
                  d.evStart = 1'b0;
               end else if (q.evStart) begin
                  d.pitchOut = shifted(curEv.pitch, q.ctrl, q.shifts);
                  d.notePulse = 1'b1;
                  d.remain = (curEv.dur == 9'h000) ? 9'h001 : curEv.dur;
                  d.evStart = 1'b0;
               end else if (tickRise && !q.ctrl[`SSC_CTRL_STEP]) begin
                  if (q.remain <= 9'h001) begin
                     d.sec = nxt.sec;
                     d.idx = nxt.idx;
                     d.wrapPulse = nxt.wrap;
                     d.evStart = 1'b1;
                  end else begin
                     d.remain = q.remain - 9'h001;
                  end
               end
            end
            default: begin
            end
         endcase
      end

      // Panel indicators, registered; section, count and full from the next state, long duration lamp from the current state
      d.panel.sec = d.sec + 2'd1;
      if (d.mode == SSC_LOAD) begin
         d.panel.cnt = d.pend ? d.idx + 5'd1 : ((d.lens[d.sec] != 5'd0) ? d.lens[d.sec] : 5'd1);
      end else if (d.mode == SSC_PLAY) begin
         d.panel.cnt = d.idx + 5'd1;
      end else begin
         d.panel.cnt = d.lens[d.sec];
      end
      d.panel.full = (d.mode == SSC_LOAD) ? (d.panel.cnt == EV5) : (d.lens[d.sec] == EV5);
      d.panel.longDur = (q.mode == SSC_LOAD) && q.pend && cntHalf;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q <= '0;
         q.ctrl <= `SSC_CTRL_RST;
      end else begin
         q <= d;
      end
   end

   assign wbRsp = q.rsp;
   assign pitchVoltageOutput = q.pitchOut;
   assign notePulseOutput = q.notePulse;
   assign wraparoundPulseOutput = q.wrapPulse;
   assign panel = q.panel;
endmodule

// >>> design/ssc_regs.svh
// Register offsets, field positions, reset values and counts of the step sequencer control.
// Assumes a Wishbone slave with an 8-bit byte address and 32-bit data.
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH

// Word aligned byte offsets
`define SSC_OFS_CTRL 8'h00
`define SSC_OFS_CMD 8'h04
`define SSC_OFS_SHIFT1 8'h08
`define SSC_OFS_SHIFT2 8'h0C
`define SSC_OFS_SHIFT3 8'h10
`define SSC_OFS_STATUS 8'h14
`define SSC_OFS_LEN 8'h18

// Control register fields
`define SSC_CTRL_CHAIN12 0
`define SSC_CTRL_CHAIN23 1
`define SSC_CTRL_STEP 2
`define SSC_CTRL_SHSEL_LO 4
`define SSC_CTRL_MASK 8'h37
`define SSC_CTRL_RST 8'h00

// Command register fields, write only pulses
`define SSC_CMD_LOAD_LO 0
`define SSC_CMD_PLAY_LO 4
`define SSC_CMD_FINISH 8

// Status register fields
`define SSC_STAT_MODE_LO 0
`define SSC_STAT_SEC_LO 8
`define SSC_STAT_CNT_LO 16
`define SSC_STAT_FULL 24
`define SSC_STAT_LONG 25

// Counts
`define SSC_EVENTS 24
`define SSC_DUR_LIMIT 256
`define SSC_PITCH_LEVELS 61

`endif

// >>> design/ssc_pkg.sv
// Types shared by the step sequencer control modules.
// Assumes ssc_regs.svh supplies the numeric constants.
package ssc_pkg;

   typedef enum logic [1:0] {SSC_IDLE, SSC_LOAD, SSC_PLAY} ssc_mode_t;

   typedef struct packed {
      logic [5:0] pitch;
      logic [8:0] dur;
   } ssc_event_t;

   typedef struct packed {
      logic [1:0] sec;
      logic [4:0] idx;
      logic wrap;
   } ssc_pos_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } ssc_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } ssc_wb_rsp_t;

   typedef struct packed {
      logic [1:0] sec;
      logic [4:0] cnt;
      logic full;
      logic longDur;
   } ssc_panel_t;

endpackage

// >>> design/ssc_section_mem.sv
// One memory section of note events, flip-flop storage.
// Assumes a single writer; read is combinational by index.
`timescale 1ns/1ps
`include "ssc_regs.svh"
module ssc_section_mem #(
   parameter int DEPTH = `SSC_EVENTS
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Write port
   input wire logic wrEn,
   input wire logic [4:0] wrIdx,
   input wire ssc_pkg::ssc_event_t wrData,
   // Read port
   input wire logic [4:0] rdIdx,
   output ssc_pkg::ssc_event_t rdData
);
   import ssc_pkg::*;

   typedef struct packed {
      ssc_event_t [DEPTH-1:0] ev;
   } ssc_mem_state_t;

   ssc_mem_state_t q, d;

   if (DEPTH < 2 || DEPTH > 31) begin : gBadDepth
      $error("section depth out of range");
   end

   always_comb begin
      d = q;
      if (wrEn && wrIdx < DEPTH[4:0]) begin
         d.ev[wrIdx] = wrData;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rdData = (rdIdx < DEPTH[4:0]) ? q.ev[rdIdx] : '0;
endmodule

// >>> design/ssc_tick_counter.sv
// Saturating counter of tick clock edges since the last clear.
// Assumes tick is a one-cycle pulse on core_clk.
`timescale 1ns/1ps
`include "ssc_regs.svh"
module ssc_tick_counter #(
   parameter int LIMIT = `SSC_DUR_LIMIT
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Control
   input wire logic tick,
   input wire logic clear,
   // Result
   output logic [8:0] count,
   output logic half
);
   typedef struct packed {
      logic [8:0] cnt;
   } ssc_cnt_state_t;

   ssc_cnt_state_t q, d;

   if (LIMIT < 2 || LIMIT > 511) begin : gBadLimit
      $error("duration limit out of range");
   end

   always_comb begin
      d = q;
      if (clear) begin
         d.cnt = 9'h000;
      end else if (tick && q.cnt < LIMIT[8:0]) begin
         d.cnt = q.cnt + 9'h001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign count = q.cnt;
   assign half = (q.cnt >= LIMIT[9:1]);
endmodule

// >>> bench/ssc_checker.sv
// Port assertions of the step sequencer control.
// Assumes binding into ssc_top; one clock, synchronous active low reset.
`timescale 1ns/1ps
`include "ssc_regs.svh"
module ssc_checker #(
   parameter int EVENTS = 24
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register bus
   input wire ssc_pkg::ssc_wb_req_t wbReq,
   input wire ssc_pkg::ssc_wb_rsp_t wbRsp,
   // Keyboard side
   input wire logic tickPulse,
   input wire logic keyboardPulseInput,
   input wire logic [5:0] pitchVoltageInput,
   // Synthesizer side
   input wire logic [6:0] pitchVoltageOutput,
   input wire logic notePulseOutput,
   input wire logic wraparoundPulseOutput,
   // Front panel
   input wire ssc_pkg::ssc_panel_t panel
);
   import ssc_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   bus_answer_a: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack)
      else $error("bus request not answered in the next cycle");
   ack_single_a: assert property (wbRsp.ack |=> !wbRsp.ack)
      else $error("bus ack longer than one cycle");
   unmapped_zero_a: assert property (wbRsp.ack && (wbReq.adr == `SSC_OFS_CMD || wbReq.adr > `SSC_OFS_LEN)
      |-> wbRsp.dat == 32'h0000_0000) else $error("write only or unmapped read not zero");
   note_single_a: assert property (notePulseOutput |=> !notePulseOutput)
      else $error("note pulse longer than one cycle");
   wrap_note_a: assert property (wraparoundPulseOutput |=> notePulseOutput && !wraparoundPulseOutput)
      else $error("wraparound pulse not followed by first note");
   pitch_hold_a: assert property ($past(rst_n) && !notePulseOutput |-> $stable(pitchVoltageOutput))
      else $error("pitch output moved outside an event start");
   full_lamp_a: assert property (panel.cnt == EVENTS |-> panel.full)
      else $error("capacity lamp dark at full count");
   count_bound_a: assert property (panel.cnt <= EVENTS)
      else $error("event count above section capacity");
   cover property (notePulseOutput);
   cover property (wraparoundPulseOutput);
   cover property (panel.full);
   cover property (panel.longDur);
endmodule

// >>> bench/ssc_keyboard_model.sv
// Keyboard partner: note pulses with a pitch code valid only at the pulse.
// Assumes noteReq is a one-cycle request from the bench on core_clk.
`timescale 1ns/1ps
module ssc_keyboard_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Bench request
   input wire logic noteReq,
   input wire logic [5:0] notePitch,
   // Keyboard side
   output logic keyboardPulseInput,
   output logic [5:0] pitchVoltageInput
);
   import ssc_pkg::*;
   // Between notes the code keeps moving, so a late sample is caught
   always @(posedge core_clk) begin
      if (!rst_n) begin
         keyboardPulseInput <= 1'b0;
         pitchVoltageInput <= 6'h00;
      end else if (noteReq) begin
         keyboardPulseInput <= 1'b1;
         pitchVoltageInput <= notePitch;
      end else begin
         keyboardPulseInput <= 1'b0;
         pitchVoltageInput <= ~pitchVoltageInput;
      end
   end
endmodule

// >>> bench/step_sequencer_control_tb.sv
// Self-checking bench of the step sequencer control.
// Assumes ssc_pkg, ssc_regs.svh, the design, checker and keyboard model are compiled.
`timescale 1ns/1ps
`include "ssc_regs.svh"
`define SSC_CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module step_sequencer_control_tb;
   import ssc_pkg::*;
   localparam int EVENTS = 24;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   ssc_wb_req_t wbReq = '0;
   ssc_wb_rsp_t wbRsp;
   logic tickPulse = 1'b0;
   logic keyboardPulseInput;
   logic [5:0] pitchVoltageInput;
   logic [6:0] pitchVoltageOutput;
   logic notePulseOutput;
   logic wraparoundPulseOutput;
   ssc_panel_t panel;
   logic noteReq = 1'b0;
   logic [5:0] notePitch = 6'h00;
   logic [31:0] seed = 32'h0000_2839;
   logic [6:0] expPitch [$];
   int expDur [$];
   logic [6:0] shiftVal = 7'h00;
   logic monOn = 1'b0;
   logic stepMode = 1'b0;
   logic tickRun = 1'b0;
   logic tickPrev = 1'b0;
   logic wrapPrev = 1'b0;
   int tickDiv = 0;
   int tickPer = 4;
   int monIdx = 0;
   int notesSeen = 0;
   int tickSeen = 0;
   int error_cnt = 0;
   int check_count = 0;
   always #4 core_clk = ~core_clk;
   ssc_top #(.EVENTS(EVENTS), .DUR_LIMIT(256)) DUT (.core_clk(core_clk), .rst_n(rst_n), .wbReq(wbReq),
      .wbRsp(wbRsp), .tickPulse(tickPulse), .keyboardPulseInput(keyboardPulseInput),
      .pitchVoltageInput(pitchVoltageInput), .pitchVoltageOutput(pitchVoltageOutput),
      .notePulseOutput(notePulseOutput), .wraparoundPulseOutput(wraparoundPulseOutput), .panel(panel));
   ssc_keyboard_model KBD (.core_clk(core_clk), .rst_n(rst_n), .noteReq(noteReq), .notePitch(notePitch),
      .keyboardPulseInput(keyboardPulseInput), .pitchVoltageInput(pitchVoltageInput));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic summarize();
      if (error_cnt == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic wbAccess(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
      int n;
      n = 0;
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
      @(posedge core_clk);
      while (wbRsp.ack !== 1'b1 && n < 50) begin
         @(posedge core_clk);
         n++;
      end
      if (n == 50) error_cnt++;
      q = wbRsp.dat;
      wbReq <= '0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] q;
      wbAccess(1'b1, adr, dat, q);
   endtask
   task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] q;
      wbAccess(1'b0, adr, 32'h0000_0000, q);
      `SSC_CHECK(q, exp)
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         tickPulse <= 1'b1;
         @(posedge core_clk);
         tickPulse <= 1'b0;
         repeat (2) @(posedge core_clk);
      end
   endtask
   task automatic note(input logic [5:0] p);
      noteReq <= 1'b1;
      notePitch <= p;
      @(posedge core_clk);
      noteReq <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask
   task automatic tickOff();
      tickRun <= 1'b0;
      @(posedge core_clk);
      tickPulse <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask
   task automatic monStart();
      monIdx = 0;
      notesSeen = 0;
      tickSeen = 0;
      monOn = 1'b1;
   endtask
   task automatic play(input int s);
      tickOff();
      monStart();
      wr(`SSC_OFS_CMD, 32'h0000_0010 << (s - 1));
      tickRun <= 1'b1;
   endtask
   task automatic waitNotes(input int n);
      int k;
      k = 0;
      while (notesSeen < n && k < 5000) begin
         @(posedge core_clk);
         k++;
      end
      `SSC_CHECK(1'(notesSeen >= n), 1'b1)
   endtask
   task automatic stopChk();
      int n;
      wr(`SSC_OFS_CMD, 32'h0000_0100);
      n = notesSeen;
      repeat (80) @(posedge core_clk);
      `SSC_CHECK(notesSeen, n)
   endtask
   // Loads n notes with random pitch (the second fixed at 6'h3F) and 1..4 ticks each, then finishes
   task automatic loadSec(input int s, input int n);
      logic [5:0] p;
      int d;
      expPitch.delete();
      expDur.delete();
      wr(`SSC_OFS_CMD, 32'h0000_0001 << (s - 1));
      `SSC_CHECK({panel.sec, panel.cnt}, {2'(s), 5'h01})
      for (int i = 0; i < n; i++) begin
         p = (i == 1) ? 6'h3F : 6'(rnd() % 61);
         d = 1 + int'(rnd() % 4);
         note(p);
         if (i == EVENTS - 1) `SSC_CHECK(panel.full, 1'b1)
         if (i == EVENTS) `SSC_CHECK({panel.sec, panel.cnt}, 7'h41)
         if (i == 2 * EVENTS) `SSC_CHECK({panel.sec, panel.cnt}, 7'h61)
         ticks(d);
         expPitch.push_back((p > 6'h3C) ? 7'h3C : {1'b0, p});
         expDur.push_back(d);
      end
      if (n <= EVENTS) `SSC_CHECK(panel.cnt, 5'(n))
      monStart();
      wr(`SSC_OFS_CMD, 32'h0000_0100);
   endtask
   always @(posedge core_clk) begin
      if (tickRun) begin
         tickDiv <= (tickDiv + 1) % tickPer;
         tickPulse <= (tickDiv == 0);
      end
   end
   // Checks each played event against the loaded pitch; outside step mode, from the second event on, also the wrap and the previous duration
   always @(posedge core_clk) begin
      if (monOn && notePulseOutput === 1'b1) begin
         `SSC_CHECK(pitchVoltageOutput, expPitch[monIdx] + shiftVal)
         if (notesSeen > 0 && !stepMode) begin
            `SSC_CHECK(tickSeen, expDur[(monIdx + expDur.size() - 1) % expDur.size()])
            `SSC_CHECK(wrapPrev, 1'(monIdx == 0))
         end
         notesSeen++;
         monIdx = (monIdx + 1) % expPitch.size();
         tickSeen = 0;
      end
      if (tickPulse === 1'b1 && tickPrev === 1'b0) tickSeen++;
      tickPrev = tickPulse;
      wrapPrev = wraparoundPulseOutput;
   end
   initial begin
      #400_000;
      error_cnt++;
      summarize();
   end
   initial begin
      logic [31:0] v;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rdChk(`SSC_OFS_CTRL, 32'h0000_0000);
      rdChk(`SSC_OFS_LEN, 32'h0000_0000);
      rdChk(8'h1C, 32'h0000_0000);
      v = rnd();
      wr(`SSC_OFS_CTRL, v);
      rdChk(`SSC_OFS_CTRL, v & 32'h0000_0037);
      wr(`SSC_OFS_CTRL, 32'h0000_0000);
      loadSec(1, 5);
      rdChk(`SSC_OFS_LEN, 32'h0000_0005);
      tickRun <= 1'b1;
      waitNotes(12);
      tickPer = 7;
      waitNotes(22);
      stopChk();
      play(1);
      waitNotes(3);
      play(1);
      waitNotes(4);
      stopChk();
      for (int s = 1; s < 4; s++) begin
         wr(8'h08 + 8'(4 * (s - 1)), 32'(s * 3));
         wr(`SSC_OFS_CTRL, 32'(s << 4));
         shiftVal = 7'(s * 3);
         play(1);
         waitNotes(6);
         stopChk();
      end
      shiftVal = 7'h00;
      wr(`SSC_OFS_CTRL, 32'h0000_0004);
      stepMode = 1'b1;
      play(1);
      for (int k = 2; k < 9; k++) begin
         wr(`SSC_OFS_CMD, 32'h0000_0010);
         repeat (20) @(posedge core_clk);
         `SSC_CHECK(notesSeen, k)
      end
      wr(`SSC_OFS_CTRL, 32'h0000_0000);
      wr(`SSC_OFS_CMD, 32'h0000_0100);
      stepMode = 1'b0;
      monOn = 1'b0;
      tickOff();
      wr(`SSC_OFS_CMD, 32'h0000_0002);
      note(6'h0C);
      ticks(127);
      `SSC_CHECK(panel.longDur, 1'b0)
      ticks(1);
      repeat (2) @(posedge core_clk);
      `SSC_CHECK(panel.longDur, 1'b1)
      ticks(140);
      wr(`SSC_OFS_CMD, 32'h0000_0100);
      wr(`SSC_OFS_CMD, 32'h0000_0100);
      rdChk(`SSC_OFS_LEN, 32'h0000_0105);
      play(1);
      waitNotes(6);
      stopChk();
      // The overlong note was held past the limit, so it replays at exactly the limit
      expPitch.delete();
      expDur.delete();
      expPitch.push_back(7'h0C);
      expDur.push_back(`SSC_DUR_LIMIT);
      play(2);
      waitNotes(3);
      stopChk();
      tickOff();
      wr(`SSC_OFS_CTRL, 32'h0000_0001);
      loadSec(1, 26);
      rdChk(`SSC_OFS_LEN, 32'h0000_0218);
      tickRun <= 1'b1;
      waitNotes(30);
      wr(`SSC_OFS_CMD, 32'h0000_0100);
      wr(`SSC_OFS_CTRL, 32'h0000_0000);
      expPitch = expPitch[EVENTS:$];
      expDur = expDur[EVENTS:$];
      play(2);
      waitNotes(5);
      stopChk();
      tickOff();
      wr(`SSC_OFS_CTRL, 32'h0000_0003);
      loadSec(1, 2 * EVENTS + 2);
      rdChk(`SSC_OFS_LEN, 32'h0002_1818);
      tickRun <= 1'b1;
      waitNotes(2 * EVENTS + 6);
      wr(`SSC_OFS_CMD, 32'h0000_0100);
      wr(`SSC_OFS_CTRL, 32'h0000_0000);
      expPitch = expPitch[2 * EVENTS:$];
      expDur = expDur[2 * EVENTS:$];
      play(3);
      waitNotes(5);
      summarize();
   end
endmodule
bind ssc_top ssc_checker #(.EVENTS(EVENTS)) CHK (.core_clk(core_clk), .rst_n(rst_n), .wbReq(wbReq),
   .wbRsp(wbRsp), .tickPulse(tickPulse), .keyboardPulseInput(keyboardPulseInput),
   .pitchVoltageInput(pitchVoltageInput), .pitchVoltageOutput(pitchVoltageOutput),
   .notePulseOutput(notePulseOutput), .wraparoundPulseOutput(wraparoundPulseOutput), .panel(panel));
